// ---- rtl/mnrd_core.sv ----
// Execute logic for move, store, no-op and return-from-interrupt.
// Assumes a file of 128 bytes, an 8-entry return stack, one clock.
`timescale 1ns/1ps
module mnrd_core (
    input  wire logic                          ref_clk,
    input  wire logic                          rst_n,
    input  wire logic                          clkEn,
    input  wire logic [mnrd_pkg::INSN_W-1:0]   insn,
    input  wire logic                          callPush,
    input  wire logic [mnrd_pkg::PC_W-1:0]     callAddr,
    output logic      [mnrd_pkg::PC_W-1:0]     progCount,
    output logic      [mnrd_pkg::DATA_W-1:0]   workReg,
    output logic                               zeroFlag,
    output logic      [mnrd_pkg::DATA_W-1:0]   intCtrl,
    output logic                               busy
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    localparam int NREG = 1 << mnrd_pkg::ADDR_W;

    logic [mnrd_pkg::DATA_W-1:0] fileMem_r [NREG];
    logic [mnrd_pkg::PC_W-1:0]   stack_r   [mnrd_pkg::DEPTH];
    logic [mnrd_pkg::SP_W-1:0]   sp_r;
    logic [mnrd_pkg::PC_W-1:0]   pc_r;
    logic [mnrd_pkg::DATA_W-1:0] wreg_r;
    logic [mnrd_pkg::DATA_W-1:0] intcr_r;
    logic                        zero_r;
    mnrd_pkg::mnrd_state_t       state_r;
    logic [mnrd_pkg::SP_W-1:0]   spTop;
    logic [mnrd_pkg::DATA_W-1:0] fileVal;

    mnrd_dec_if dec ();

    mnrd_decode u_decode (
        .insn (insn),
        .dec  (dec)
    );

    assign fileVal = fileMem_r[dec.addr];
    assign spTop   = sp_r - 3'h1;

    wire logic exec     = clkEn && state_r == mnrd_pkg::MNRD_FETCH;
    wire logic doMove   = exec && dec.op == mnrd_pkg::MNRD_OP_MOVE;
    wire logic doStore  = exec && dec.op == mnrd_pkg::MNRD_OP_STORE;
    wire logic doReturn = exec && dec.op == mnrd_pkg::MNRD_OP_RETURN;

    // ----------------------------------------------------------------
    // Sequencing: return takes a second, flush cycle
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= mnrd_pkg::MNRD_FETCH;
        end else if (clkEn) begin
            case (state_r)
                mnrd_pkg::MNRD_FETCH: begin
                    if (doReturn) begin
                        state_r <= mnrd_pkg::MNRD_FLUSH;
                    end
                end
                mnrd_pkg::MNRD_FLUSH: begin
                    state_r <= mnrd_pkg::MNRD_FETCH;
                end
                default: begin
                    state_r <= mnrd_pkg::MNRD_FETCH;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Program counter and return stack
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_r <= mnrd_pkg::PC_RST;
        end else if (exec) begin
            if (doReturn) begin
                pc_r <= stack_r[spTop];
            end else begin
                pc_r <= pc_r + 13'h0001;
            end
        end
    end

    // Stack wraps silently on overflow, as a circular buffer would
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_r <= '0;
        end else if (doReturn) begin
            sp_r <= spTop;
        end else if (clkEn && callPush) begin
            sp_r <= sp_r + 3'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clkEn && callPush && !doReturn) begin
            stack_r[sp_r] <= callAddr;
        end
    end

    // ----------------------------------------------------------------
    // Working register, flags, interrupt control
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wreg_r <= mnrd_pkg::WREG_RST;
        end else if (doMove && !dec.dest) begin
            wreg_r <= fileVal;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            zero_r <= 1'b0;
        end else if (doMove) begin
            zero_r <= fileVal == 8'h00;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            intcr_r <= mnrd_pkg::INTCR_RST;
        end else if (doReturn) begin
            intcr_r[mnrd_pkg::IRQ_EN_BIT] <= 1'b1;
        end
    end

    // File: move with dest 1 writes back the same value
    always_ff @(posedge ref_clk) begin
        if (doStore) begin
            fileMem_r[dec.addr] <= wreg_r;
        end else if (doMove && dec.dest) begin
            fileMem_r[dec.addr] <= fileVal;
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    assign progCount = pc_r;
    assign workReg   = wreg_r;
    assign zeroFlag  = zero_r;
    assign intCtrl   = intcr_r;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
        end else if (clkEn) begin
            busy <= doReturn;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_move_wreg: assert property (@(posedge ref_clk) disable iff (!rst_n)
        doMove && !dec.dest |=> wreg_r == $past(fileVal))
        else $error("move to working register lost value");
    a_move_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        doMove |=> zero_r == ($past(fileVal) == 8'h00))
        else $error("zero flag wrong after move");
    a_store_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        doStore |=> $stable(zero_r) && $stable(wreg_r))
        else $error("store changed a flag or working register");
    a_ret_pc: assert property (@(posedge ref_clk) disable iff (!rst_n)
        doReturn |=> pc_r == $past(stack_r[spTop]) && sp_r == $past(spTop))
        else $error("return did not pop stack");
    a_ret_gie: assert property (@(posedge ref_clk) disable iff (!rst_n)
        doReturn |=> intcr_r[mnrd_pkg::IRQ_EN_BIT])
        else $error("return did not set interrupt enable");
    a_ret_cycles: assert property (@(posedge ref_clk) disable iff (!rst_n)
        doReturn && clkEn ##1 clkEn |=> state_r == mnrd_pkg::MNRD_FETCH)
        else $error("return not two cycles");
    a_ret_stall: assert property (@(posedge ref_clk) disable iff (!rst_n)
        doReturn ##1 1'b1 |=> $stable(pc_r) && $stable(wreg_r))
        else $error("instruction executed during return flush");
    a_nop_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && dec.op == mnrd_pkg::MNRD_OP_NOP |=>
        pc_r == $past(pc_r) + 13'h0001 && $stable(wreg_r) && $stable(zero_r))
        else $error("no-op changed state");

endmodule

// ---- rtl/mnrd_decode.sv ----
// Combinational instruction decoder for the four supported opcodes.
// Assumes the instruction word is stable while it is executed.
`timescale 1ns/1ps
module mnrd_decode (
    input  wire logic [mnrd_pkg::INSN_W-1:0] insn,
    mnrd_dec_if.decoder                      dec
);

    always_comb begin
        dec.op   = mnrd_pkg::MNRD_OP_NONE;
        dec.dest = insn[mnrd_pkg::DEST_BIT];
        dec.addr = insn[mnrd_pkg::ADDR_W-1:0];
        if (insn[13:8] == mnrd_pkg::OPC_MOVE_FROM_FILE) begin
            dec.op = mnrd_pkg::MNRD_OP_MOVE;
        end else if (insn[13:7] == mnrd_pkg::OPC_STORE_HI) begin
            dec.op = mnrd_pkg::MNRD_OP_STORE;
        end else if (insn == mnrd_pkg::RETURN_INT_CODE) begin
            dec.op = mnrd_pkg::MNRD_OP_RETURN;
        end else if ((insn & mnrd_pkg::NOP_MASK) == mnrd_pkg::NOP_CODE) begin
            dec.op = mnrd_pkg::MNRD_OP_NOP;
        end
    end

endmodule

// ---- shared/mnrd_dec_if.sv ----
// Decoded instruction fields passed from decoder to execute logic.
// Assumes both ends share ref_clk.
`timescale 1ns/1ps
interface mnrd_dec_if;
    mnrd_pkg::mnrd_op_t               op;
    logic                             dest;
    logic [mnrd_pkg::ADDR_W-1:0]      addr;
    modport decoder (output op, output dest, output addr);
    modport execute (input op, input dest, input addr);
endinterface

// ---- shared/mnrd_pkg.sv ----
// Constants and types for the move / store / no-op / return decoder.
// Assumes a 14-bit instruction word and an 8-bit data path.
package mnrd_pkg;

    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PC_W   = 13;
    localparam int DEPTH  = 8;
    localparam int SP_W   = 3;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    localparam logic [5:0]  OPC_MOVE_FROM_FILE = 6'h08;
    localparam logic [6:0]  OPC_STORE_HI       = 7'h01;
    localparam logic [13:0] NOP_MASK           = 14'h3f9f;
    localparam logic [13:0] NOP_CODE           = 14'h0000;
    localparam logic [13:0] RETURN_INT_CODE    = 14'h0009;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int DEST_BIT   = 7;
    localparam int IRQ_EN_BIT = 7;
    localparam int RETURN_CYC = 2;
    localparam logic [DATA_W-1:0] WREG_RST  = 8'h00;
    localparam logic [DATA_W-1:0] INTCR_RST = 8'h00;
    localparam logic [PC_W-1:0]   PC_RST    = 13'h0000;

    typedef enum logic [1:0] {
        MNRD_FETCH = 2'b00,
        MNRD_FLUSH = 2'b01
    } mnrd_state_t;

    typedef enum logic [2:0] {
        MNRD_OP_NONE,
        MNRD_OP_MOVE,
        MNRD_OP_STORE,
        MNRD_OP_NOP,
        MNRD_OP_RETURN
    } mnrd_op_t;

endpackage

// ---- verification/move_nop_return_decode_test.sv ----
// Self-checking bench for the move / store / no-op / return execute core.
// Assumes mnrd_pkg and mnrd_dec_if are compiled first; no partner model.
`timescale 1ns/1ps
module move_nop_return_decode_test;

    logic                          ref_clk;
    logic                          rst_n;
    logic                          clkEn;
    logic [mnrd_pkg::INSN_W-1:0]   insn;
    logic                          callPush;
    logic [mnrd_pkg::PC_W-1:0]     callAddr;
    logic [mnrd_pkg::PC_W-1:0]     progCount;
    logic [mnrd_pkg::DATA_W-1:0]   workReg;
    logic                          zeroFlag;
    logic [mnrd_pkg::DATA_W-1:0]   intCtrl;
    logic                          busy;
    int                            num_errors;
    int                            checked;

    mnrd_core u_mnrd_core (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .clkEn     (clkEn),
        .insn      (insn),
        .callPush  (callPush),
        .callAddr  (callAddr),
        .progCount (progCount),
        .workReg   (workReg),
        .zeroFlag  (zeroFlag),
        .intCtrl   (intCtrl),
        .busy      (busy)
    );

    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One instruction, then clkEn drops so it is taken exactly once
    task automatic issue(input logic [13:0] i);
        @(posedge ref_clk);
        insn  <= i;
        clkEn <= 1'b1;
        @(posedge ref_clk);
        clkEn <= 1'b0;
        #1;
    endtask

    task automatic push(input logic [12:0] a);
        @(posedge ref_clk);
        callPush <= 1'b1;
        callAddr <= a;
        insn     <= 14'h0000;
        clkEn    <= 1'b1;
        @(posedge ref_clk);
        callPush <= 1'b0;
        clkEn    <= 1'b0;
        #1;
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // W is zero after reset, so only a zero value can reach the file
    task automatic t_store_move();
        issue(14'h00ff);
        chk("pc store", progCount, 16'h0001);
        chk("zero store", zeroFlag, 16'h0000);
        issue(14'h087f);
        chk("w move", workReg, 16'h0000);
        chk("zero move", zeroFlag, 16'h0001);
        chk("pc move", progCount, 16'h0002);
        issue(14'h08ff);
        chk("zero test", zeroFlag, 16'h0001);
        chk("w test", workReg, 16'h0000);
        chk("pc test", progCount, 16'h0003);
    endtask

    task automatic t_nop();
        issue(14'h0000);
        chk("pc nop a", progCount, 16'h0004);
        issue(14'h0060);
        chk("pc nop b", progCount, 16'h0005);
        chk("zero nop", zeroFlag, 16'h0001);
        chk("ictl nop", intCtrl, 16'h0000);
    endtask

    task automatic t_return();
        push(13'h0abc);
        issue(14'h0009);
        chk("pc ret", progCount, 16'h0abc);
        chk("ien ret", intCtrl, 16'h0080);
        chk("busy ret", busy, 16'h0001);
        chk("zero ret", zeroFlag, 16'h0001);
        @(posedge ref_clk);
        #1;
        chk("busy frozen", busy, 16'h0001);
        issue(14'h0000);
        chk("pc flush", progCount, 16'h0abc);
        chk("busy flush", busy, 16'h0000);
        issue(14'h0000);
        chk("pc after", progCount, 16'h0abd);
        chk("ien after", intCtrl, 16'h0080);
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        num_errors = 0;
        checked    = 0;
        rst_n      = 1'b0;
        clkEn      = 1'b0;
        insn       = 14'h0000;
        callPush   = 1'b0;
        callAddr   = 13'h0000;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        chk("pc rst", progCount, 16'h0000);
        chk("w rst", workReg, 16'h0000);
        chk("zero rst", zeroFlag, 16'h0000);
        chk("ictl rst", intCtrl, 16'h0000);
        chk("busy rst", busy, 16'h0000);
        t_store_move();
        t_nop();
        t_return();
        end_of_test();
    end

    // Whole run is about 24 cycles; this is ample margin
    initial begin
        #200000;
        num_errors++;
        end_of_test();
    end

endmodule
